// file: include/bpc_pkg.sv
// Shared constants for the byte parity checker link and both of its ends.
package bpc_pkg;

   // Dual-port byte addresses of the function_control_byte register.
   localparam logic [15:0] BPC_CMD_ADDR_JUMPERED = 16'h0000;
   localparam logic [15:0] BPC_CMD_ADDR_DEFAULT = 16'h0400;

   // Function control byte: field positions and value after reset.
   localparam int BPC_CMD_W = 4;
   localparam int BPC_CMD_EVEN_BIT = 0;
   localparam int BPC_CMD_MASKABLE_ERROR_IRQ_EN_BIT = 1;
   localparam int BPC_CMD_NMI_EN_BIT = 2;
   localparam int BPC_CMD_IND_EN_BIT = 3;
   localparam logic [3:0] BPC_CMD_RESET = 4'h0;

   // Parity memory shape: one bank word index, two byte lanes.
   localparam int BPC_IDX_W = 14;
   localparam int BPC_DATA_W = 16;
   localparam int BPC_LANES = 2;

   // Host sequencer: clocks spent in each strobe phase.
   localparam int BPC_STEP_CYC = 8;

   // Host register map, byte offsets on the Wishbone bus.
   localparam logic [7:0] BPC_REG_CTRL = 8'h00;
   localparam logic [7:0] BPC_REG_ADDR = 8'h04;
   localparam logic [7:0] BPC_REG_WDATA = 8'h08;
   localparam logic [7:0] BPC_REG_RDATA = 8'h0c;
   localparam logic [7:0] BPC_REG_STATUS = 8'h10;
   localparam logic [7:0] BPC_REG_INHIBIT = 8'h14;

   // Host register fields.
   localparam int BPC_CTRL_START_BIT = 0;
   localparam int BPC_CTRL_WRITE_BIT = 1;
   localparam int BPC_STAT_MASKABLE_ERROR_IRQ_BIT = 0;
   localparam int BPC_STAT_NMI_BIT = 1;
   localparam int BPC_STAT_LOW_BIT = 2;
   localparam int BPC_STAT_HIGH_BIT = 3;
   localparam int BPC_STAT_BUSY_BIT = 4;

endpackage : bpc_pkg

// file: include/bpc_link_if.sv
// Link between the base board memory controller and the parity add-on.
`timescale 1ns/100ps
interface bpc_link_if;
   // Lines from the base board; the seven strobes are active low.
   logic row_strobe_bank0_n;
   logic row_strobe_bank1_n;
   logic col_strobe_n;
   logic write_strobe_n;
   logic write_enable_strobe_n;
   logic transfer_ack_n;
   logic dual_port_read_n;
   logic [15:1] decoded_address_bits;
   logic nonmaskable_irq_inhibit;
   // Shared data bus, one driver pair per end.
   logic [15:0] host_data;
   logic host_data_oe_n;
   logic [15:0] dev_data;
   logic dev_data_oe_n;
   logic [15:0] data_bus;
   // Error lines back to the base board.
   logic maskable_error_irq;
   logic nonmaskable_error_irq;
   logic low_byte_indicator;
   logic high_byte_indicator;

   // Resolved bus level; an undriven bus floats high through pull-ups.
   assign data_bus = !dev_data_oe_n ? dev_data : (!host_data_oe_n ? host_data : 16'hffff);

   modport device (
      input row_strobe_bank0_n, row_strobe_bank1_n, col_strobe_n, write_strobe_n,
      input write_enable_strobe_n, transfer_ack_n, dual_port_read_n,
      input decoded_address_bits, nonmaskable_irq_inhibit, data_bus,
      output dev_data, dev_data_oe_n, maskable_error_irq, nonmaskable_error_irq,
      output low_byte_indicator, high_byte_indicator
   );

   modport host (
      output row_strobe_bank0_n, row_strobe_bank1_n, col_strobe_n, write_strobe_n,
      output write_enable_strobe_n, transfer_ack_n, dual_port_read_n,
      output decoded_address_bits, nonmaskable_irq_inhibit, host_data, host_data_oe_n,
      input data_bus, maskable_error_irq, nonmaskable_error_irq,
      input low_byte_indicator, high_byte_indicator
   );

endinterface : bpc_link_if

// file: rtl/bpc_parity_device.sv
// Parity add-on end: parity memory, generator/checker, command latch and error latches.
//
// The Wishbone register port was decided locally.
`timescale 1ns/100ps
module bpc_parity_device
   import bpc_pkg::*;
#(
   parameter int IDX_W = BPC_IDX_W
) (
   // Clock and synchronous reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Link to the base board.
   bpc_link_if.device link,
   // Board jumpers, high when installed.
   input wire logic addr_jumper_i,
   input wire logic inhibit_polarity_jumper_i,
   // Error lamps.
   output logic low_led_o,
   output logic high_led_o
);

   localparam int SYNC_W = 10 + 15 + BPC_DATA_W;

   // Synchroniser stages for every pin that enters the block.
   logic [SYNC_W-1:0] pin_raw;
   logic [SYNC_W-1:0] pin_meta_reg;
   logic [SYNC_W-1:0] pin_sync_reg;

   // Synchronised pin levels.
   logic ras0_n;
   logic row_strobe_bank1_n_n;
   logic cas_n;
   logic wr_n;
   logic we_n;
   logic ack_n;
   logic dual_port_read_n_n;
   logic inhibit;
   logic addr_jmp;
   logic pol_jmp;
   logic [15:1] addr_s;
   logic [BPC_DATA_W-1:0] bus_s;

   // Edge detection.
   logic [2:0] edge_prev_reg;
   logic cas_rise;
   logic cas_fall;
   logic we_rise;
   logic ack_rise;

   // Latches and state.
   logic [BPC_DATA_W-1:0] data_latch_reg;
   logic [BPC_CMD_W-1:0] cmd_reg;
   logic bank_reg;
   logic row_valid_reg;
   logic [IDX_W-1:0] idx_reg;
   logic maskable_error_irq_reg;
   logic nonmaskable_irq_reg;
   logic low_ind_reg;
   logic high_ind_reg;

   // Parity path.
   logic [BPC_LANES-1:0] par_mem [0:1][0:(2**IDX_W)-1];
   logic [BPC_LANES-1:0] stored_par;
   logic [BPC_LANES-1:0] lane_result;
   logic write_event;
   logic check_event;
   logic error_event;
   logic cmd_hit;
   logic inhibit_active;

   // All pins share one two-stage synchroniser, so the relative order of
   // strobe, address and data changes is kept intact on the inside.
   assign pin_raw = {link.row_strobe_bank0_n, link.row_strobe_bank1_n, link.col_strobe_n,
                     link.write_strobe_n, link.write_enable_strobe_n, link.transfer_ack_n,
                     link.dual_port_read_n, link.nonmaskable_irq_inhibit, addr_jumper_i,
                     inhibit_polarity_jumper_i, link.decoded_address_bits, link.data_bus};

   // Two flip-flops before any logic reads a pin.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_meta_reg <= '1;
         pin_sync_reg <= '1;
      end else begin
         pin_meta_reg <= pin_raw;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // Unpack the synchronised pins.
   assign {ras0_n, row_strobe_bank1_n_n, cas_n, wr_n, we_n, ack_n, dual_port_read_n_n, inhibit, addr_jmp, pol_jmp,
           addr_s, bus_s} = pin_sync_reg;

   // Previous strobe levels; idle high after reset so no false edge appears.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         edge_prev_reg <= '1;
      end else begin
         edge_prev_reg <= {cas_n, we_n, ack_n};
      end
   end

   // Strobe edges, each one clock wide.
   assign cas_rise = cas_n & ~edge_prev_reg[2];
   assign cas_fall = ~cas_n & edge_prev_reg[2];
   assign we_rise = we_n & ~edge_prev_reg[1];
   assign ack_rise = ack_n & ~edge_prev_reg[0];

   // Data bus latches follow the base board acknowledge.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_latch_reg <= '0;
      end else if (ack_rise) begin
         data_latch_reg <= bus_s;
      end
   end

   // Latch outputs drive the bus only while the base board reads them.
   assign link.dev_data = data_latch_reg;
   assign link.dev_data_oe_n = dual_port_read_n_n;

   // Command address decode; address bit zero is not decoded.
   assign cmd_hit = ({addr_s, 1'b0} == (addr_jmp ? BPC_CMD_ADDR_JUMPERED
                                                : BPC_CMD_ADDR_DEFAULT));

   // Command latch: four low bus bits on the write enable rise.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_reg <= BPC_CMD_RESET;
      end else if (we_rise && cmd_hit) begin
         cmd_reg <= bus_s[BPC_CMD_W-1:0];
      end
   end

   // Bank and word are caught when the column strobe falls. A column cycle
   // with no row strobe low is a refresh and touches neither bank.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bank_reg <= 1'b0;
         row_valid_reg <= 1'b0;
         idx_reg <= '0;
      end else if (cas_fall) begin
         bank_reg <= ~row_strobe_bank1_n_n;
         row_valid_reg <= ~ras0_n | ~row_strobe_bank1_n_n;
         idx_reg <= addr_s[IDX_W:1];
      end
   end

   // Column strobe rise ends the cycle: write stores, read checks.
   assign write_event = cas_rise & ~wr_n & row_valid_reg;
   assign check_event = cas_rise & wr_n & row_valid_reg;
   assign error_event = check_event & (|lane_result);

   // Parity memory, one bit per byte lane in each bank. It is not cleared,
   // like the dynamic parts it stands for, so a location must be written
   // before its first read is meaningful.
   always_ff @(posedge clk_i) begin
      if (!rst_i && write_event) begin
         par_mem[bank_reg][idx_reg] <= lane_result;
      end
   end
   assign stored_par = par_mem[bank_reg][idx_reg];

   // One independent generator/checker per byte lane.
   for (genvar g = 0; g < BPC_LANES; g++) begin : g_lane
      logic stored_in;
      logic circuit_out;
      // The write strobe gates the stored bit off during writes.
      assign stored_in = wr_n & stored_par[g];
      assign circuit_out = ~(^{data_latch_reg[8*g +: 8], stored_in});
      // Inverting the selection flips every stored bit, forcing later errors.
      assign lane_result[g] = circuit_out ^ cmd_reg[BPC_CMD_EVEN_BIT];
   end

   // Maskable interrupt latch; a cleared enable bit both clears and masks,
   // so a set can never meet a clear in the same cycle.
   always_ff @(posedge clk_i) begin
      if (rst_i || !cmd_reg[BPC_CMD_MASKABLE_ERROR_IRQ_EN_BIT]) begin
         maskable_error_irq_reg <= 1'b0;
      end else if (error_event) begin
         maskable_error_irq_reg <= 1'b1;
      end
   end

   // Inhibit sense follows the polarity jumper.
   assign inhibit_active = inhibit ^ pol_jmp;

   // Non-maskable latch; the inhibit level holds it reset and wins over a set.
   always_ff @(posedge clk_i) begin
      if (rst_i || !cmd_reg[BPC_CMD_NMI_EN_BIT] || inhibit_active) begin
         nonmaskable_irq_reg <= 1'b0;
      end else if (error_event) begin
         nonmaskable_irq_reg <= 1'b1;
      end
   end

   // Indicators are sticky and only collect lanes when the maskable latch sets.
   always_ff @(posedge clk_i) begin
      if (rst_i || !cmd_reg[BPC_CMD_IND_EN_BIT]) begin
         low_ind_reg <= 1'b0;
         high_ind_reg <= 1'b0;
      end else if (error_event && cmd_reg[BPC_CMD_MASKABLE_ERROR_IRQ_EN_BIT]) begin
         low_ind_reg <= low_ind_reg | lane_result[0];
         high_ind_reg <= high_ind_reg | lane_result[1];
      end
   end

   // Outputs straight from the latches.
   assign link.maskable_error_irq = maskable_error_irq_reg;
   assign link.nonmaskable_error_irq = nonmaskable_irq_reg;
   assign link.low_byte_indicator = low_ind_reg;
   assign link.high_byte_indicator = high_ind_reg;
   assign low_led_o = low_ind_reg;
   assign high_led_o = high_ind_reg;

endmodule : bpc_parity_device

// file: rtl/bpc_base_host.sv
// Base board end: Wishbone command registers and the memory cycle sequencer.
`timescale 1ns/100ps
module bpc_base_host
   import bpc_pkg::*;
#(
   parameter int STEP_CYC = BPC_STEP_CYC,
   parameter int RAM_W = 15
) (
   // Clock and synchronous reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Classic Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Link to the parity add-on.
   bpc_link_if.host link
);

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SETUP = 3'h1,
      ST_LATCH = 3'h2,
      ST_CAS = 3'h3,
      ST_DUAL_PORT_READ_N = 3'h4,
      ST_END = 3'h5
   } bpc_host_state_t;

   bpc_host_state_t state_reg;
   bpc_host_state_t state_next;
   logic [7:0] step_cnt_reg;
   logic step_done;
   logic wb_hit;
   logic start;
   logic op_wr_reg;
   logic [15:0] addr_reg;
   logic [15:0] wdata_reg;
   logic [15:0] rdata_reg;
   logic inhibit_reg;
   logic [15:0] ram [0:(2**RAM_W)-1];
   logic [19:0] in_meta_reg;
   logic [19:0] in_sync_reg;
   logic [6:0] strobe_reg;
   logic [15:0] hdata_reg;
   logic hdata_oe_n_reg;

   // Device lines are pins here too: two flip-flops first. The four status
   // lines are packed in register-map order so the status read needs no shuffle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_meta_reg <= '0;
         in_sync_reg <= '0;
      end else begin
         in_meta_reg <= {link.high_byte_indicator, link.low_byte_indicator,
                         link.nonmaskable_error_irq, link.maskable_error_irq, link.data_bus};
         in_sync_reg <= in_meta_reg;
      end
   end

   // A request is served in the cycle after it is seen, acknowledged once.
   assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign start = wb_hit & wb_we_i & (wb_adr_i == BPC_REG_CTRL) & wb_sel_i[0]
                  & wb_dat_i[BPC_CTRL_START_BIT] & (state_reg == ST_IDLE);

   // Register writes, honouring byte lanes.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr_reg <= '0;
         wdata_reg <= '0;
         inhibit_reg <= 1'b0;
         op_wr_reg <= 1'b0;
      end else if (wb_hit && wb_we_i) begin
         for (int b = 0; b < 2; b++) begin
            if (wb_sel_i[b] && wb_adr_i == BPC_REG_ADDR) addr_reg[8*b +: 8] <= wb_dat_i[8*b +: 8];
            if (wb_sel_i[b] && wb_adr_i == BPC_REG_WDATA) wdata_reg[8*b +: 8] <= wb_dat_i[8*b +: 8];
         end
         if (wb_sel_i[0] && wb_adr_i == BPC_REG_INHIBIT) inhibit_reg <= wb_dat_i[0];
         if (start) op_wr_reg <= wb_dat_i[BPC_CTRL_WRITE_BIT];
      end
   end

   // Read data and acknowledge; unmapped offsets read zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_hit;
         unique case (wb_adr_i)
            BPC_REG_ADDR: wb_dat_o <= {16'h0000, addr_reg};
            BPC_REG_WDATA: wb_dat_o <= {16'h0000, wdata_reg};
            BPC_REG_RDATA: wb_dat_o <= {16'h0000, rdata_reg};
            BPC_REG_STATUS: wb_dat_o <= {27'h0000000, state_reg != ST_IDLE, in_sync_reg[19:16]};
            BPC_REG_INHIBIT: wb_dat_o <= {31'h00000000, inhibit_reg};
            default: wb_dat_o <= '0;
         endcase
      end
   end

   // Sequencer: every phase lasts STEP_CYC clocks.
   assign step_done = (step_cnt_reg == 8'(STEP_CYC - 1));
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: if (start) state_next = ST_SETUP;
         ST_SETUP: if (step_done) state_next = ST_LATCH;
         ST_LATCH: if (step_done) state_next = ST_CAS;
         ST_CAS: if (step_done) state_next = op_wr_reg ? ST_END : ST_DUAL_PORT_READ_N;
         ST_DUAL_PORT_READ_N: if (step_done) state_next = ST_END;
         ST_END: if (step_done) state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   // State and step counter.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ST_IDLE;
         step_cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         step_cnt_reg <= (state_next != state_reg) ? 8'h00 : step_cnt_reg + 8'h01;
      end
   end

   // Base memory write at the end of a write, read capture at the end of the latch read.
   always_ff @(posedge clk_i) begin
      if (!rst_i && state_reg == ST_CAS && step_done && op_wr_reg) begin
         ram[addr_reg[RAM_W:1]] <= wdata_reg;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_reg <= '0;
      end else if (state_reg == ST_DUAL_PORT_READ_N && step_done) begin
         rdata_reg <= in_sync_reg[15:0];
      end
   end

   // Strobes from flip-flops, order {ras0,row_strobe_bank1_n,cas,wr,we,ack,dual_port_read_n}, all low active.
   // Acknowledge and write enable rise together, so the command latch sees the data.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strobe_reg <= 7'h7f;
         hdata_reg <= '0;
         hdata_oe_n_reg <= 1'b1;
      end else begin
         strobe_reg <= 7'h7f;
         hdata_oe_n_reg <= 1'b1;
         hdata_reg <= op_wr_reg ? wdata_reg : ram[addr_reg[RAM_W:1]];
         unique case (state_reg)
            ST_SETUP: begin
               strobe_reg <= {addr_reg[15], ~addr_reg[15], 1'b0, ~op_wr_reg, ~op_wr_reg, 2'b01};
               hdata_oe_n_reg <= 1'b0;
            end
            ST_LATCH: begin
               strobe_reg <= {addr_reg[15], ~addr_reg[15], 1'b0, ~op_wr_reg, 3'b111};
               hdata_oe_n_reg <= 1'b0;
            end
            ST_CAS: strobe_reg <= {addr_reg[15], ~addr_reg[15], 1'b1, ~op_wr_reg, 3'b111};
            ST_DUAL_PORT_READ_N: strobe_reg <= 7'h7e;
            default: strobe_reg <= 7'h7f;
         endcase
      end
   end

   // Link outputs.
   assign {link.row_strobe_bank0_n, link.row_strobe_bank1_n, link.col_strobe_n,
           link.write_strobe_n, link.write_enable_strobe_n, link.transfer_ack_n,
           link.dual_port_read_n} = strobe_reg;
   assign link.decoded_address_bits = addr_reg[15:1];
   assign link.nonmaskable_irq_inhibit = inhibit_reg;
   assign link.host_data = hdata_reg;
   assign link.host_data_oe_n = hdata_oe_n_reg;

endmodule : bpc_base_host

// file: verif/bpc_assertions.sv
// Concurrent checks on the link between the base board end and the parity add-on end.
`timescale 1ns/100ps
module bpc_assertions (
   // Clock, reset and jumper.
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic inhibit_polarity_jumper_i,
   // Link signals.
   input wire logic row_strobe_bank0_n,
   input wire logic row_strobe_bank1_n,
   input wire logic col_strobe_n,
   input wire logic write_strobe_n,
   input wire logic write_enable_strobe_n,
   input wire logic dual_port_read_n,
   input wire logic [15:1] decoded_address_bits,
   input wire logic nonmaskable_irq_inhibit,
   input wire logic dev_data_oe_n,
   input wire logic maskable_error_irq,
   input wire logic nonmaskable_error_irq,
   input wire logic low_byte_indicator,
   input wire logic high_byte_indicator
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // The top address bit picks the bank, so a wrong bank shows as a strobe mismatch.
   a_bank_lower_half: assert property (!row_strobe_bank0_n |-> !decoded_address_bits[15])
      else $error("lower bank strobed for an upper address");
   a_bank_upper_half: assert property (!row_strobe_bank1_n |-> decoded_address_bits[15])
      else $error("upper bank strobed for a lower address");
   // Errors may only be raised after the column strobe of a read.
   a_maskable_error_irq_after_read: assert property ($rose(maskable_error_irq) |->
      col_strobe_n && $past(write_strobe_n))
      else $error("maskable error raised outside a read end");
   a_nmi_after_read: assert property ($rose(nonmaskable_error_irq) |->
      col_strobe_n && $past(write_strobe_n))
      else $error("nonmaskable error raised outside a read end");
   // Inhibiting level is the input turned round by the jumper; five clocks cover the synchroniser.
   a_inhibit_holds_nmi: assert property (
      (nonmaskable_irq_inhibit ^ inhibit_polarity_jumper_i)[*5] |-> !nonmaskable_error_irq)
      else $error("nonmaskable error not held by inhibit");
   // The maskable latch only clears through a command write; the fall trails
   // the write enable rise by the synchroniser, the edge detect and two latches.
   a_maskable_error_irq_sticky: assert property ($fell(maskable_error_irq) |->
      !$past(write_enable_strobe_n, 5))
      else $error("maskable error dropped outside a command write");
   // Indicators are only taken when the maskable latch is set.
   a_low_ind_with_maskable_error_irq: assert property ($rose(low_byte_indicator) |-> maskable_error_irq)
      else $error("low indicator set without maskable error");
   a_high_ind_with_maskable_error_irq: assert property ($rose(high_byte_indicator) |-> maskable_error_irq)
      else $error("high indicator set without maskable error");
   // The device drives the bus only while the read strobe is low.
   a_drive_on_read: assert property ($fell(dual_port_read_n) |-> ##[1:4] !dev_data_oe_n)
      else $error("device did not drive on dual port read");
   a_release_when_idle: assert property (dual_port_read_n[*4] |-> dev_data_oe_n)
      else $error("device drives the bus without a read");
endmodule : bpc_assertions

// file: verif/byte_parity_checker_tb.sv
// Self-checking bench joining both ends of the byte parity checker.
`timescale 1ns/100ps
module byte_parity_checker_tb;
   import bpc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
   logic [7:0] wb_adr = 8'h00;
   logic [31:0] wb_wdat = 32'h0, wb_rdat;
   logic addr_jmp = 1'b0, pol_jmp = 1'b0, low_led, high_led;
   int fail_count = 0, tests_run = 0;

   // Both ends meet on one link; the checker watches it.
   bpc_link_if link ();
   bpc_parity_device i_bpc_parity_device (.clk_i(clk_i), .rst_i(rst_i), .link(link),
      .addr_jumper_i(addr_jmp), .inhibit_polarity_jumper_i(pol_jmp),
      .low_led_o(low_led), .high_led_o(high_led));
   bpc_base_host i_bpc_base_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'h3),
      .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .link(link));
   bpc_assertions i_bpc_assertions (.clk_i(clk_i), .rst_i(rst_i),
      .inhibit_polarity_jumper_i(pol_jmp), .row_strobe_bank0_n(link.row_strobe_bank0_n),
      .row_strobe_bank1_n(link.row_strobe_bank1_n), .col_strobe_n(link.col_strobe_n),
      .write_strobe_n(link.write_strobe_n), .write_enable_strobe_n(link.write_enable_strobe_n),
      .dual_port_read_n(link.dual_port_read_n), .decoded_address_bits(link.decoded_address_bits),
      .nonmaskable_irq_inhibit(link.nonmaskable_irq_inhibit), .dev_data_oe_n(link.dev_data_oe_n),
      .maskable_error_irq(link.maskable_error_irq),
      .nonmaskable_error_irq(link.nonmaskable_error_irq),
      .low_byte_indicator(link.low_byte_indicator),
      .high_byte_indicator(link.high_byte_indicator));

   // Free-running system clock.
   always #50 clk_i = ~clk_i;

   // Counts every comparison and reports a mismatch at once.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // One classic cycle; entered just after an edge, data is taken at the edge that sees ack.
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                     output logic [31:0] q);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_wdat <= d;
      @(posedge clk_i);
      while (wb_ack !== 1'b1) @(posedge clk_i);
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   // One memory cycle on the link; the wait on busy is cut only by the watchdog.
   task automatic mem(input logic wr, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] q);
      logic [31:0] r;
      wb(1'b1, BPC_REG_ADDR, {16'h0, a}, r);
      if (wr) wb(1'b1, BPC_REG_WDATA, {16'h0, d}, r);
      wb(1'b1, BPC_REG_CTRL, {30'h0, wr, 1'b1}, r);
      r = 32'h10;
      while (r[BPC_STAT_BUSY_BIT] !== 1'b0) wb(1'b0, BPC_REG_STATUS, 32'h0, r);
      wb(1'b0, BPC_REG_RDATA, 32'h0, r);
      q = r[15:0];
   endtask : mem

   // Status and lamps against {high, low, nmi, maskable_error_irq}. Six clocks first let a
   // change ride through both synchronisers before the status is read.
   task automatic stat(input logic [3:0] e, input string what);
      logic [31:0] r;
      repeat (6) @(posedge clk_i);
      wb(1'b0, BPC_REG_STATUS, 32'h0, r);
      check({26'h0, high_led, low_led, r[3:0]}, {26'h0, e[3:2], e[3:0]}, what);
   endtask : stat

   task automatic t_reset();
      logic [31:0] r;
      stat(4'h0, "status after reset");
      wb(1'b0, 8'h20, 32'h0, r);
      check(r, 32'h0, "unmapped read");
      $display("Test reset done");
   endtask : t_reset

   // Good data in both halves and both parity senses reads back clean.
   task automatic t_clean();
      logic [15:0] q;
      logic [15:0] adr [3] = '{16'h0010, 16'h8010, 16'h0012};
      logic [15:0] dat [3] = '{16'h0301, 16'h00ff, 16'h0107};
      mem(1'b1, 16'h0400, 16'h000e, q);
      for (int i = 0; i < 3; i++) begin
         if (i == 2) mem(1'b1, 16'h0400, 16'h000f, q);
         mem(1'b1, adr[i], dat[i], q);
         mem(1'b0, adr[i], 16'h0, q);
         check({16'h0, q}, {16'h0, dat[i]}, "read back");
         stat(4'h0, "clean read");
      end
      mem(1'b1, 16'h0400, 16'h000e, q);
      $display("Test clean done");
   endtask : t_clean

   // A write under inverted sense leaves wrong parity in both lanes.
   task automatic t_force();
      logic [15:0] q;
      mem(1'b1, 16'h0400, 16'h000f, q);
      mem(1'b1, 16'h0020, 16'h0301, q);
      mem(1'b1, 16'h0400, 16'h000e, q);
      mem(1'b0, 16'h0020, 16'h0, q);
      check({16'h0, q}, 32'h0301, "forced read data");
      stat(4'hf, "forced error");
      $display("Test force done");
   endtask : t_force

   // Inhibit clears the nonmaskable latch; the jumper turns its sense round.
   task automatic t_inhibit();
      logic [15:0] q;
      logic [31:0] r;
      wb(1'b1, BPC_REG_INHIBIT, 32'h1, r);
      stat(4'hd, "inhibit high clears");
      wb(1'b1, BPC_REG_INHIBIT, 32'h0, r);
      pol_jmp <= 1'b1;
      mem(1'b0, 16'h0020, 16'h0, q);
      stat(4'hd, "inverted inhibit low holds");
      wb(1'b1, BPC_REG_INHIBIT, 32'h1, r);
      mem(1'b0, 16'h0020, 16'h0, q);
      stat(4'hf, "nonmaskable set again");
      pol_jmp <= 1'b0;
      wb(1'b1, BPC_REG_INHIBIT, 32'h0, r);
      stat(4'hd, "polarity restored");
      $display("Test inhibit done");
   endtask : t_inhibit

   // Only the jumpered offset takes a clearing command.
   task automatic t_decode();
      logic [15:0] q;
      mem(1'b1, 16'h0c00, 16'h0000, q);
      stat(4'hd, "extra address bit refused");
      addr_jmp <= 1'b1;
      mem(1'b1, 16'h0400, 16'h0000, q);
      stat(4'hd, "default offset refused");
      mem(1'b1, 16'h0000, 16'h0000, q);
      stat(4'h0, "command clear");
      addr_jmp <= 1'b0;
      $display("Test decode done");
   endtask : t_decode

   // Main sequence after a 12 cycle reset.
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_clean();
      t_force();
      t_inhibit();
      t_decode();
      tally_and_finish();
   end

   // Watchdog well beyond the thousand or so cycles the tests need.
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      tally_and_finish();
   end
endmodule : byte_parity_checker_tb
